// file: hw/cmt_timer.sv
`timescale 1ns/10ps
module cmt_timer (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [cmt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cmt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic event_in,
	output logic [1:0] timer_out,
	output logic [1:0] match_flag
);
	import cmt_pkg::*;

	cmt_ctrl_t ctrl_q;
	cmt_ctrl_t ctrl_d;
	cmt_outctl_t outctl_q;
	cmt_flags_t flags_q;
	cmt_flags_t flags_d;
	logic [PRESC_SEL_W-1:0] presc_q;
	logic [CNT_W-1:0] period_q;
	logic [CNT_W-1:0] second_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [DATA_W-1:0] rdata_q;
	logic event_prev_q;
	logic armed_q;
	logic [1:0] win_q;
	logic [1:0] win_d;
	logic suppress_q;
	logic suppress_d;
	logic [1:0] match_flag_q;

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	wire sel_ctrl = reg_addr == OFF_CTRL;
	wire sel_presc = reg_addr == OFF_PRESC;
	wire sel_outctl = reg_addr == OFF_OUTCTL;
	wire sel_oneshot = reg_addr == OFF_ONESHOT;
	wire sel_period = reg_addr == OFF_PERIOD;
	wire sel_second = reg_addr == OFF_SECOND;
	wire sel_count = reg_addr == OFF_COUNT;
	wire sel_flags = reg_addr == OFF_FLAGS;

	wire wr_ctrl = reg_wr && sel_ctrl;
	wire wr_presc = reg_wr && sel_presc;
	wire wr_outctl = reg_wr && sel_outctl;
	wire wr_oneshot = reg_wr && sel_oneshot;
	wire wr_period = reg_wr && sel_period;
	wire wr_second = reg_wr && sel_second;
	wire wr_flags = reg_wr && sel_flags;

	wire cmt_ctrl_t ctrl_wr_val = cmt_ctrl_t'(reg_wdata[CTRL_W-1:0]);
	wire cmt_oneshot_t os_cmd = wr_oneshot ? cmt_oneshot_t'(reg_wdata[ONESHOT_W-1:0]) : '0;
	wire cmt_flags_t flags_clr = wr_flags ? cmt_flags_t'(reg_wdata[FLAGS_W-1:0]) : '0;

	assign ctrl_d = wr_ctrl ? ctrl_wr_val : ctrl_q;

	// ------------------------------------------------------------------
	// start and stop
	// ------------------------------------------------------------------
	wire running = ctrl_q.count_enable;
	wire start_now = wr_ctrl && !running && ctrl_wr_val.count_enable;
	wire stop_now = wr_ctrl && running && !ctrl_wr_val.count_enable;

	wire mode_ppg = ctrl_q.mode == CMT_MODE_PPG;
	wire mode_oneshot = ctrl_q.mode == CMT_MODE_ONESHOT;
	wire mode_event = ctrl_q.mode == CMT_MODE_EVENT;

	// ------------------------------------------------------------------
	// count clock and event input
	// ------------------------------------------------------------------
	logic tick;

	// the prescaler never waits for a start, so the first count comes
	// anywhere up to one count clock after the enable write
	cmt_prescaler #(
		.SEL_W(PRESC_SEL_W),
		.DIV_W(PRESC_DIV_W)
	) u_presc (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.sel(presc_q),
		.tick(tick)
	);

	wire event_edge = event_in && !event_prev_q;

	// the first edge after a start only arms the counter, so the count
	// reads 0 both before and after it
	wire arm_now = running && mode_event && event_edge && !armed_q;
	wire count_src = mode_event ? (event_edge && armed_q) : tick;
	wire inc = running && count_src;

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	wire ppg_wrap = mode_ppg && (count_q == period_q);
	wire [CNT_W-1:0] count_plus = CNT_W'(count_q + CNT_W'(1));
	wire [CNT_W-1:0] cnt_next = ppg_wrap ? CNT_RST : count_plus;
	wire overflow = inc && !ppg_wrap && (count_q == CNT_MAX);
	wire cycle_start = inc && (cnt_next == CNT_RST);

	assign count_d = start_now ? CNT_RST : inc ? cnt_next : count_q;

	// ------------------------------------------------------------------
	// compare channels
	// ------------------------------------------------------------------
	logic match0;
	logic match1;
	logic stop_hit0;
	logic stop_hit1;

	// pulse mode: cycle start sets the first output active, second match
	// ends its duty; stopping forces both enabled outputs active
	wire ppg_stop = stop_now && mode_ppg;
	wire set0 = (mode_ppg && cycle_start) || ppg_stop || os_cmd.trig0;
	wire clr0 = (mode_ppg && match1) || (mode_oneshot && (match0 || os_cmd.reset0));
	wire tog0 = !mode_ppg && !mode_oneshot && match0;

	wire set1 = ppg_stop || os_cmd.trig1;
	wire clr1 = mode_oneshot && (match1 || os_cmd.reset1);
	wire tog1 = !mode_oneshot && match1;

	// in one-shot mode no increment happens once stopped, so the pins
	// keep the level they had
	cmt_compare #(
		.W(CNT_W)
	) u_cmp0 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.inc(inc),
		.cnt_q(count_q),
		.cnt_next(cnt_next),
		.cmp(period_q),
		.blind(wr_period),
		.stop_now(stop_now),
		.ev_set(set0 && (mode_ppg || mode_oneshot)),
		.ev_clr(clr0),
		.ev_tog(tog0),
		.oe(outctl_q.oe0),
		.alv(outctl_q.alv0),
		.match(match0),
		.stop_hit(stop_hit0),
		.pin_q(timer_out[0])
	);

	cmt_compare #(
		.W(CNT_W)
	) u_cmp1 (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.inc(inc),
		.cnt_q(count_q),
		.cnt_next(cnt_next),
		.cmp(second_q),
		.blind(wr_second),
		.stop_now(stop_now),
		.ev_set(set1 && (mode_ppg || mode_oneshot)),
		.ev_clr(clr1),
		.ev_tog(tog1),
		.oe(outctl_q.oe1),
		.alv(outctl_q.alv1),
		.match(match1),
		.stop_hit(stop_hit1),
		.pin_q(timer_out[1])
	);

	// ------------------------------------------------------------------
	// lost period request after an early stop
	// ------------------------------------------------------------------
	// the window covers the count clocks right after a period match;
	// a stop inside it eats the next period request, unless a second match or an overflow comes first
	wire win_open = win_q != 2'h0;

	assign win_d = match0 ? SUPPRESS_WIN_TICKS :
		(stop_now ? 2'h0 : (win_open && tick) ? 2'(win_q - 2'h1) : win_q);

	wire consume = suppress_q && match0;

	assign suppress_d = (stop_now && win_open) ? 1'b1 :
		(overflow || match1 || consume) ? 1'b0 : suppress_q;

	// ------------------------------------------------------------------
	// request flags, set wins over a clear in the same cycle
	// ------------------------------------------------------------------
	wire cmt_flags_t flags_set = '{
		overflow: overflow,
		event_seen: event_edge,
		second: match1 || stop_hit1,
		first: (match0 && !suppress_q) || (stop_hit0 && !win_open)
	};

	assign flags_d = cmt_flags_t'((flags_q & ~flags_clr) | flags_set);

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	wire [DATA_W-1:0] rd_mux =
		sel_ctrl ? DATA_W'(ctrl_q) :
		sel_presc ? DATA_W'(presc_q) :
		sel_outctl ? DATA_W'(outctl_q) :
		sel_period ? period_q :
		sel_second ? second_q :
		sel_count ? count_q :
		sel_flags ? DATA_W'(flags_q) :
		'0;

	assign reg_rdata = rdata_q;
	assign match_flag = match_flag_q;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= CTRL_RST;
			presc_q <= PRESC_RST;
			outctl_q <= OUTCTL_RST;
		end else begin
			ctrl_q <= ctrl_d;
			if (wr_presc) begin
				presc_q <= reg_wdata[PRESC_SEL_W-1:0];
			end
			if (wr_outctl) begin
				outctl_q <= cmt_outctl_t'(reg_wdata[OUTCTL_W-1:0]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			period_q <= CMP_RST;
			second_q <= CMP_RST;
		end else begin
			if (wr_period) begin
				period_q <= reg_wdata;
			end
			if (wr_second) begin
				second_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count_q <= CNT_RST;
			event_prev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			count_q <= count_d;
			event_prev_q <= event_in;
			armed_q <= start_now ? 1'b0 : (armed_q || arm_now);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			win_q <= 2'h0;
			suppress_q <= 1'b0;
			flags_q <= FLAGS_RST;
			match_flag_q <= 2'h0;
		end else begin
			win_q <= win_d;
			suppress_q <= suppress_d;
			flags_q <= flags_d;
			match_flag_q <= {flags_d.second, flags_d.first};
		end
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : '0;
		end
	end
endmodule

// file: hw/cmt_pkg.sv
package cmt_pkg;

	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int PRESC_SEL_W = 4;
	localparam int PRESC_DIV_W = 11;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PRESC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_OUTCTL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ONESHOT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SECOND = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1c;

	// field widths within the 16-bit data word, all from bit 0
	localparam int CTRL_W = 3;
	localparam int OUTCTL_W = 4;
	localparam int ONESHOT_W = 4;
	localparam int FLAGS_W = 4;

	typedef enum logic [1:0] {
		CMT_MODE_FREE,
		CMT_MODE_PPG,
		CMT_MODE_ONESHOT,
		CMT_MODE_EVENT
	} cmt_mode_t;

	// bit 0 count enable, bits 2:1 mode
	typedef struct packed {
		cmt_mode_t mode;
		logic count_enable;
	} cmt_ctrl_t;

	// bit 0 enable0, bit 1 active level0, bit 2 enable1, bit 3 active level1
	typedef struct packed {
		logic alv1;
		logic oe1;
		logic alv0;
		logic oe0;
	} cmt_outctl_t;

	// bit 0 trigger0, bit 1 reset0, bit 2 trigger1, bit 3 reset1
	typedef struct packed {
		logic reset1;
		logic trig1;
		logic reset0;
		logic trig0;
	} cmt_oneshot_t;

	// bit 0 first match, bit 1 second match, bit 2 event edge, bit 3 overflow
	typedef struct packed {
		logic overflow;
		logic event_seen;
		logic second;
		logic first;
	} cmt_flags_t;

	localparam cmt_ctrl_t CTRL_RST = 3'h0;
	localparam cmt_outctl_t OUTCTL_RST = 4'h0;
	localparam cmt_flags_t FLAGS_RST = 4'h0;
	localparam logic [PRESC_SEL_W-1:0] PRESC_RST = 4'h0;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

	// 1.5 count clocks after a period match, rounded up to whole ticks
	localparam logic [1:0] SUPPRESS_WIN_TICKS = 2'h2;

endpackage

// file: hw/cmt_prescaler.sv
`timescale 1ns/10ps
module cmt_prescaler #(
	parameter int SEL_W = 4,
	parameter int DIV_W = 11
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [SEL_W-1:0] sel,
	output logic tick
);
	import cmt_pkg::*;

	logic [DIV_W-1:0] div_q;
	wire [DIV_W-1:0] one = DIV_W'(1);
	// selects beyond the divider width saturate at the slowest rate
	wire [DIV_W-1:0] mask = DIV_W'((one << sel) - one);

	// free running so a start lands anywhere inside a count clock
	assign tick = (div_q & mask) == mask;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
		end else begin
			div_q <= DIV_W'(div_q + one);
		end
	end
endmodule

// file: hw/cmt_compare.sv
`timescale 1ns/10ps
module cmt_compare #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic inc,
	input wire logic [W-1:0] cnt_q,
	input wire logic [W-1:0] cnt_next,
	input wire logic [W-1:0] cmp,
	input wire logic blind,
	input wire logic stop_now,
	input wire logic ev_set,
	input wire logic ev_clr,
	input wire logic ev_tog,
	input wire logic oe,
	input wire logic alv,
	output logic match,
	output logic stop_hit,
	output logic pin_q
);
	import cmt_pkg::*;

	logic act_q;
	logic act_d;

	// only an increment can match, and a compare write blinds the channel
	assign match = inc && !blind && (cnt_next == cmp);
	assign stop_hit = stop_now && !blind && (cnt_q == cmp);

	assign act_d = ev_set ? 1'b1 : ev_clr ? 1'b0 : ev_tog ? !act_q : act_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			act_q <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			act_q <= act_d;
			pin_q <= oe ? (act_d ? alv : !alv) : !alv;
		end
	end
endmodule

// file: sim/cmt_timer_checker.sv
`timescale 1ns/10ps
module cmt_timer_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [cmt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic event_in,
	input wire logic [1:0] timer_out,
	input wire logic [1:0] match_flag
);
	import cmt_pkg::*;
	// shadows of control words; the checks need the mode, which no port shows
	logic [2:0] ctrl_q;
	logic [3:0] oc_q;
	wire wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
	wire wr_oc = reg_wr && reg_addr == OFF_OUTCTL;
	wire [2:0] ctrl_d = wr_ctrl ? reg_wdata[2:0] : ctrl_q;
	wire [3:0] oc_d = wr_oc ? reg_wdata[3:0] : oc_q;
	wire ppg_stop = wr_ctrl && !reg_wdata[0] && ctrl_q == 3'h3 && oc_q[0];
	wire os_stopped = ctrl_q == 3'h4;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= 3'h0;
			oc_q <= 4'h0;
		end else begin
			ctrl_q <= ctrl_d;
			oc_q <= oc_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_reset_out: assert property ($rose(resetn) |->
		timer_out == 2'h3 && match_flag == 2'h0) else $error("outputs wrong after reset");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside read slot");
	a_flag0_sticky: assert property ($fell(match_flag[0]) |->
		$past(reg_wr && reg_addr == OFF_FLAGS && reg_wdata[0])) else $error("flag 0 lost");
	a_flag1_sticky: assert property ($fell(match_flag[1]) |->
		$past(reg_wr && reg_addr == OFF_FLAGS && reg_wdata[1])) else $error("flag 1 lost");
	a_blind_first: assert property (reg_wr && reg_addr == OFF_PERIOD && !match_flag[0]
		|=> !match_flag[0]) else $error("match during period write");
	a_blind_second: assert property (reg_wr && reg_addr == OFF_SECOND && !match_flag[1]
		|=> !match_flag[1]) else $error("match during second write");
	a_off_level: assert property (!oc_q[0] && $stable(oc_q) |->
		timer_out[0] == !oc_q[1]) else $error("disabled output level wrong");
	a_ppg_stop: assert property (ppg_stop |=> (timer_out[0] == oc_q[1])[*2])
		else $error("pulse stop not active");
	a_oneshot_hold: assert property (os_stopped && !reg_wr && !$past(reg_wr) |=>
		$stable(timer_out)) else $error("one-shot output moved while stopped");
	cover property (ppg_stop);
	cover property ($rose(match_flag[0]));
	cover property (os_stopped && timer_out[0]);
endmodule

bind cmt_timer cmt_timer_checker i_chk (.clk_sys(clk_sys), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .event_in(event_in), .timer_out(timer_out),
	.match_flag(match_flag));

// file: sim/cmt_far_side.sv
`timescale 1ns/10ps
module cmt_far_side (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic fire,
	input wire logic [1:0] timer_out,
	output logic event_in,
	output logic [7:0] rises0
);
	// one clean edge per request, held two clocks so it cannot be missed
	logic [1:0] hold_q;
	logic prev_q;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hold_q <= 2'h0;
			prev_q <= 1'b0;
			rises0 <= 8'h00;
		end else begin
			hold_q <= fire ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
			prev_q <= timer_out[0];
			rises0 <= rises0 + {7'h00, timer_out[0] && !prev_q};
		end
	end
	assign event_in = hold_q != 2'h0;
endmodule

// file: sim/cmt_timer_bench.sv
`timescale 1ns/10ps
module cmt_timer_bench;
	import cmt_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic fire = 1'b0;
	logic [15:0] reg_rdata;
	logic event_in;
	logic [1:0] timer_out;
	logic [1:0] match_flag;
	logic [7:0] rises0;
	logic [15:0] v;
	logic [15:0] p;
	logic [15:0] s;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 96;
	int hi;
	int lo;
	always #10 clk_sys = ~clk_sys;
	cmt_timer i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.event_in(event_in), .timer_out(timer_out), .match_flag(match_flag));
	cmt_far_side i_far (.clk_sys(clk_sys), .resetn(resetn), .fire(fire),
		.timer_out(timer_out), .event_in(event_in), .rises0(rises0));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic look(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		while (match_flag[b] !== 1'b1 && n < 400) begin
			look(1);
			n++;
		end
		chk("flag wait", 16'h0001, {15'h0000, match_flag[b]});
	endtask
	task automatic measure(output int h, output int l);
		int n;
		n = 0;
		h = 0;
		l = 0;
		look(1);
		while (timer_out[0] !== 1'b0 && n < 99) begin
			look(1);
			n++;
		end
		while (timer_out[0] !== 1'b1 && n < 99) begin
			look(1);
			n++;
		end
		while (timer_out[0] === 1'b1 && h < 99) begin
			look(1);
			h++;
		end
		while (timer_out[0] === 1'b0 && l < 99) begin
			look(1);
			l++;
		end
	endtask
	function automatic int low_len(input logic [15:0] per, input logic [15:0] sec);
		return int'(per) + 1 - int'(sec);
	endfunction
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		look(1);
		chk("out at reset", 16'h0003, {14'h0000, timer_out});
		v = 16'($random(seed));
		wr(OFF_PERIOD, v);
		rd(OFF_PERIOD, p);
		chk("period readback", v, p);
		wr(OFF_COUNT, 16'h1234);
		rd(OFF_COUNT, p);
		chk("count read-only", 16'h0000, p);
		wr(8'h20, 16'hffff);
		rd(8'h20, p);
		chk("unmapped", 16'h0000, p);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_OUTCTL, {12'h000, k[1], 1'b0, k[0], 1'b0});
			look(2);
			chk("disabled out", {14'h0000, ~k[1:0]}, {14'h0000, timer_out});
		end
		// slow ticks; align to a fresh increment so the count cannot move mid-check
		wr(OFF_PRESC, 16'h000a);
		wr(OFF_CTRL, 16'h0001);
		rd(OFF_COUNT, p);
		v = p;
		for (int i = 0; i < 700 && v === p; i++) begin
			rd(OFF_COUNT, v);
		end
		wr(OFF_PERIOD, v);
		wr(OFF_SECOND, v);
		rd(OFF_FLAGS, p);
		chk("equal compare write", 16'h0000, p);
		wr(OFF_CTRL, 16'h0000);
		rd(OFF_FLAGS, p);
		chk("flags on stop at match", 16'h0003, p);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_PRESC, 16'h0004);
		wr(OFF_PERIOD, 16'h0005);
		wr(OFF_SECOND, 16'h0009);
		wr(OFF_CTRL, 16'h0001);
		lo = cyc;
		wait_flag(0);
		hi = cyc - lo;
		// four count clocks of 16 cycles, plus up to one late start clock
		chk("first interval", 16'h0001, {15'h0000, hi >= 65 && hi <= 81});
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_CTRL, 16'h0001);
		wait_flag(1);
		rd(OFF_FLAGS, v);
		chk("suppressed period flag", 16'h0002, v);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_CTRL, 16'h0000);
		rd(OFF_FLAGS, v);
		chk("second flag on stop", 16'h0002, v);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_CTRL, 16'h0001);
		wait_flag(0);
		rd(OFF_FLAGS, v);
		chk("channels apart", 16'h0001, v);
		// stop inside the window again, then let a second match come first
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_SECOND, 16'h0003);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_CTRL, 16'h0001);
		wait_flag(0);
		rd(OFF_FLAGS, v);
		chk("period flag after second", 16'h0003, v);
		repeat (48) @(posedge clk_sys);
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_PRESC, 16'h0000);
		wr(OFF_OUTCTL, 16'h000f);
		for (int i = 0; i < 3; i++) begin
			p = 16'h0004 + 16'({$random(seed)} % 13);
			s = 16'h0001 + 16'({$random(seed)} % (p - 16'h0001));
			wr(OFF_PERIOD, p);
			wr(OFF_SECOND, s);
			wr(OFF_CTRL, 16'h0003);
			measure(hi, lo);
			chk("pulse high", s, 16'(hi));
			chk("pulse low", 16'(low_len(p, s)), 16'(lo));
			wr(OFF_CTRL, 16'h0002);
			look(2);
			chk("stopped pulse outs", 16'h0003, {14'h0000, timer_out});
		end
		wr(OFF_CTRL, 16'h0004);
		wr(OFF_PERIOD, 16'h0014);
		wr(OFF_SECOND, 16'h8000);
		wr(OFF_ONESHOT, 16'h000a);
		wr(OFF_CTRL, 16'h0005);
		v = {8'h00, rises0};
		wr(OFF_ONESHOT, 16'h0001);
		look(1);
		chk("trigger active", 16'h0001, {14'h0000, timer_out});
		look(30);
		chk("one pulse", v + 16'h0001, {8'h00, rises0});
		chk("match ends pulse", 16'h0000, {14'h0000, timer_out});
		wr(OFF_ONESHOT, 16'h0004);
		look(1);
		chk("trigger 1 active", 16'h0002, {14'h0000, timer_out});
		wr(OFF_ONESHOT, 16'h0008);
		look(1);
		chk("reset inactive", 16'h0000, {14'h0000, timer_out});
		wr(OFF_CTRL, 16'h0004);
		wr(OFF_CTRL, 16'h0005);
		wr(OFF_ONESHOT, 16'h0001);
		wr(OFF_CTRL, 16'h0004);
		// stopped long before the count reaches the compare, so only the stop keeps it active
		look(30);
		chk("stop holds", 16'h0001, {14'h0000, timer_out});
		wr(OFF_CTRL, 16'h0006);
		wr(OFF_FLAGS, 16'h000f);
		wr(OFF_CTRL, 16'h0007);
		rd(OFF_COUNT, v);
		chk("count before edge", 16'h0000, v);
		for (int e = 0; e < 2; e++) begin
			@(posedge clk_sys);
			fire <= 1'b1;
			@(posedge clk_sys);
			fire <= 1'b0;
			look(6);
			rd(OFF_COUNT, v);
			chk("edge count", 16'(e), v);
			rd(OFF_FLAGS, v);
			chk("event flag", 16'h0004, v & 16'h0004);
		end
		wrap_up;
	end
endmodule
